// ---- tlp_pkg.sv ----
// package: constants for the three-level pwm soft-start sequencer
package tlp_pkg;

    // register offsets
    localparam logic [3:0] TLP_REG_CTRL      = 4'h0;
    localparam logic [3:0] TLP_REG_TON_DLY   = 4'h1;
    localparam logic [3:0] TLP_REG_TOFF_DLY  = 4'h2;
    localparam logic [3:0] TLP_REG_DUTY      = 4'h3;
    localparam logic [3:0] TLP_REG_RSENSE    = 4'h4;
    localparam logic [3:0] TLP_REG_STATUS    = 4'h5;

    // ctrl field positions
    localparam int TLP_CTRL_ON_BIT      = 0;
    localparam int TLP_CTRL_USE_CMD_BIT = 1;
    localparam int TLP_CTRL_USE_PIN_BIT = 2;
    localparam int TLP_CTRL_TRI25_BIT   = 3;
    localparam int TLP_CTRL_SMART_BIT   = 4;

    // reset values
    localparam logic [15:0] TLP_CTRL_RST   = 16'h0006;
    localparam logic [15:0] TLP_DLY_RST    = 16'h0000;
    localparam logic [15:0] TLP_DUTY_RST   = 16'h0080;
    // sense resistance in microohm: 0.244 .. 7.747 mohm
    localparam logic [15:0] TLP_RSENSE_MIN = 16'h00F4;
    localparam logic [15:0] TLP_RSENSE_MAX = 16'h1E43;
    localparam logic [15:0] TLP_RSENSE_RST = 16'h01F4;
    // current-monitor range breakpoints, microohm: last values not above 0.5795 and 1.1285 mohm
    localparam logic [15:0] TLP_RANGE_BRK1 = 16'h0243;
    localparam logic [15:0] TLP_RANGE_BRK2 = 16'h0468;
    // monitor full-scale, mV
    localparam logic [7:0]  TLP_CM_24MV    = 8'h18;
    localparam logic [7:0]  TLP_CM_40MV    = 8'h28;
    localparam logic [7:0]  TLP_CM_60MV    = 8'h3C;

    // timing
    localparam int TLP_CLK_MHZ         = 10;
    localparam int TLP_TRI_DRIVE_NS    = 20;
    localparam int TLP_TRI_DRIVE_CYC_R = (TLP_TRI_DRIVE_NS * TLP_CLK_MHZ + 999) / 1000;
    localparam int TLP_TRI_DRIVE_CYC   = (TLP_TRI_DRIVE_CYC_R < 1) ? 1 : TLP_TRI_DRIVE_CYC_R;
    localparam int TLP_STAGE1_PERIODS  = 15;

    // phase output levels
    typedef enum logic [1:0] {
        TLP_LVL_TRI  = 2'b00,
        TLP_LVL_HIGH = 2'b01,
        TLP_LVL_LOW  = 2'b10
    } tlp_level_e;

    // sequencer states
    typedef enum logic [2:0] {
        TLP_ST_OFF    = 3'b000,
        TLP_ST_TONDLY = 3'b001,
        TLP_ST_SS1    = 3'b010,
        TLP_ST_SS2    = 3'b011,
        TLP_ST_SS3    = 3'b100,
        TLP_ST_RUN    = 3'b101,
        TLP_ST_TOFDLY = 3'b110
    } tlp_state_e;

endpackage : tlp_pkg

// ---- tlp_tri_driver.sv ----
// phase pin driver: three levels with timed tri-state entry drive
`timescale 1ns/1ps
module tlp_tri_driver
    import tlp_pkg::*;
(
    // clock and reset
    input  wire logic       sys_clk_in,
    input  wire logic       rst_b_in,
    // requested level and tri-state entry level
    input  wire logic [1:0] level_in,
    input  wire logic       tri_lvl_25_in,
    // pin side
    output logic            pwm_hi_out,
    output logic            pwm_lo_out,
    output logic            pwm_tri_lvl_25_out,
    output logic            pwm_oe_b_out
);

    ////////////////////////////////////////////////////////////////////////////
    localparam int CW = $clog2(TLP_TRI_DRIVE_CYC + 1);

    logic [1:0]    prev_q,  prev_d;
    logic [CW-1:0] hold_q,  hold_d;
    logic          hi_q,    hi_d;
    logic          lo_q,    lo_d;
    logic          l25_q,   l25_d;
    logic          oe_b_q,  oe_b_d;

    always_comb begin
        prev_d = level_in;
        hold_d = hold_q;
        hi_d   = (level_in == TLP_LVL_HIGH);
        lo_d   = (level_in == TLP_LVL_LOW);
        l25_d  = l25_q;
        oe_b_d = 1'b0;
        if (level_in == TLP_LVL_TRI) begin
            if (prev_q != TLP_LVL_TRI) begin
                // drive the entry level so the stage sees a clean tri-state window
                hold_d = CW'(TLP_TRI_DRIVE_CYC);
                l25_d  = tri_lvl_25_in;
                oe_b_d = 1'b0;
            end else if (hold_q != '0) begin
                hold_d = hold_q - 1'b1;
                oe_b_d = (hold_q == CW'(1));
            end else begin
                oe_b_d = 1'b1;
            end
        end else begin
            hold_d = '0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            prev_q <= TLP_LVL_TRI;
            hold_q <= '0;
            hi_q   <= 1'b0;
            lo_q   <= 1'b0;
            l25_q  <= 1'b0;
            oe_b_q <= 1'b1;
        end else begin
            prev_q <= prev_d;
            hold_q <= hold_d;
            hi_q   <= hi_d;
            lo_q   <= lo_d;
            l25_q  <= l25_d;
            oe_b_q <= oe_b_d;
        end
    end

    assign pwm_hi_out         = hi_q;
    assign pwm_lo_out         = lo_q;
    assign pwm_tri_lvl_25_out = l25_q;
    assign pwm_oe_b_out       = oe_b_q;

endmodule : tlp_tri_driver

// ---- tlp_sequencer.sv ----
// top: on/off control, delays, three-stage soft-start and register port
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
module tlp_sequencer
    import tlp_pkg::*;
#(
    parameter int PER_W  = 8,
    parameter int PERIOD = 100
) (
    // clock and reset
    input  wire logic              sys_clk_in,
    input  wire logic              rst_b_in,
    // register port
    input  wire logic [3:0]        reg_addr_in,
    input  wire logic [15:0]       reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    output logic [15:0]            reg_rdata_out,
    // on/off sources
    input  wire logic              enable_pin_in,
    input  wire logic              vin_ok_in,
    // temperature sources
    input  wire logic [11:0]       temp_sense_input_in,
    input  wire logic [11:0]       stage_temp_output_in,
    output logic [11:0]            temp_out,
    // current monitor
    output logic [7:0]             cm_range_mv_out,
    // phase pin
    output logic                   pwm_hi_out,
    output logic                   pwm_lo_out,
    output logic                   pwm_tri_lvl_25_out,
    output logic                   pwm_oe_b_out,
    output logic                   soft_start_done_out
);

    if (PERIOD < 4 || PERIOD >= (1 << PER_W)) begin : g_bad_period
        $error("tlp_sequencer: PERIOD does not fit PER_W");
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: three flops, change accepted when last two agree
    logic [2:0] en_sync_q,  vin_sync_q;
    logic       en_q,  en_d,  vin_q,  vin_d;

    always_comb begin
        en_d  = (en_sync_q[1] == en_sync_q[2]) ? en_sync_q[2] : en_q;
        vin_d = (vin_sync_q[1] == vin_sync_q[2]) ? vin_sync_q[2] : vin_q;
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            en_sync_q  <= 3'b000;
            vin_sync_q <= 3'b000;
            en_q       <= 1'b0;
            vin_q      <= 1'b0;
        end else begin
            en_sync_q  <= {en_sync_q[1:0], enable_pin_in};
            vin_sync_q <= {vin_sync_q[1:0], vin_ok_in};
            en_q       <= en_d;
            vin_q      <= vin_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [15:0] ctrl_q,  ctrl_d;
    logic [15:0] ton_q,   ton_d;
    logic [15:0] toff_q,  toff_d;
    logic [15:0] duty_q,  duty_d;
    logic [15:0] rs_q,    rs_d;
    logic        smart_q, smart_d;
    logic        smart_valid_q, smart_valid_d;
    logic [15:0] rdata_q, rdata_d;
    tlp_state_e  state_q, state_d;

    function automatic logic [15:0] clamp_rs(input logic [15:0] v);
        if (v < TLP_RSENSE_MIN)      return TLP_RSENSE_MIN;
        else if (v > TLP_RSENSE_MAX) return TLP_RSENSE_MAX;
        else                         return v;
    endfunction : clamp_rs

    always_comb begin
        ctrl_d        = ctrl_q;
        ton_d         = ton_q;
        toff_d        = toff_q;
        duty_d        = duty_q;
        rs_d          = rs_q;
        smart_valid_d = 1'b1;
        // mode is latched once after reset from the ctrl reset value; later writes never reach it
        smart_d       = smart_valid_q ? smart_q : ctrl_q[TLP_CTRL_SMART_BIT];
        rdata_d       = 16'h0000;
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                TLP_REG_CTRL:     ctrl_d = {11'h000, reg_wdata_in[4:0]};
                TLP_REG_TON_DLY:  ton_d  = reg_wdata_in;
                TLP_REG_TOFF_DLY: toff_d = reg_wdata_in;
                TLP_REG_DUTY:     duty_d = reg_wdata_in;
                TLP_REG_RSENSE:   rs_d   = clamp_rs(reg_wdata_in);
                default:          ;
            endcase
        end
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                TLP_REG_CTRL:     rdata_d = ctrl_q;
                TLP_REG_TON_DLY:  rdata_d = ton_q;
                TLP_REG_TOFF_DLY: rdata_d = toff_q;
                TLP_REG_DUTY:     rdata_d = duty_q;
                TLP_REG_RSENSE:   rdata_d = rs_q;
                TLP_REG_STATUS:   rdata_d = {11'h000, smart_q, vin_q, state_q};
                default:          rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctrl_q        <= TLP_CTRL_RST;
            ton_q         <= TLP_DLY_RST;
            toff_q        <= TLP_DLY_RST;
            duty_q        <= TLP_DUTY_RST;
            rs_q          <= TLP_RSENSE_RST;
            smart_q       <= 1'b0;
            smart_valid_q <= 1'b0;
            rdata_q       <= 16'h0000;
        end else begin
            ctrl_q        <= ctrl_d;
            ton_q         <= ton_d;
            toff_q        <= toff_d;
            duty_q        <= duty_d;
            rs_q          <= rs_d;
            smart_q       <= smart_d;
            smart_valid_q <= smart_valid_d;
            rdata_q       <= rdata_d;
        end
    end

    assign reg_rdata_out = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // monitor range and temperature source
    logic [7:0]  cm_q, cm_d;
    logic [11:0] temp_q, temp_d;

    always_comb begin
        if (rs_q <= TLP_RANGE_BRK1)      cm_d = TLP_CM_24MV;
        else if (rs_q <= TLP_RANGE_BRK2) cm_d = TLP_CM_40MV;
        else                             cm_d = TLP_CM_60MV;
        temp_d = smart_q ? stage_temp_output_in : temp_sense_input_in;
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cm_q   <= TLP_CM_24MV;
            temp_q <= 12'h000;
        end else begin
            cm_q   <= cm_d;
            temp_q <= temp_d;
        end
    end

    assign cm_range_mv_out = cm_q;
    assign temp_out        = temp_q;

    ////////////////////////////////////////////////////////////////////////////
    // on/off sequencer; delays are in switching periods
    logic [PER_W-1:0] ph_q,   ph_d;
    logic [15:0]      dly_q,  dly_d;
    logic [PER_W-1:0] hi_w_q, hi_w_d;
    logic [PER_W-1:0] lo_w_q, lo_w_d;
    logic [1:0]       lvl;
    logic             want_on, per_end;
    logic [PER_W-1:0] target;

    localparam logic [PER_W-1:0] PER_M1 = PER_W'(PERIOD - 1);

    // either source may be masked; both enabled means both must ask
    assign want_on = vin_q
                   && (!ctrl_q[TLP_CTRL_USE_CMD_BIT] || ctrl_q[TLP_CTRL_ON_BIT])
                   && (!ctrl_q[TLP_CTRL_USE_PIN_BIT] || en_q);
    assign per_end = (ph_q == PER_M1);
    assign target  = (duty_q[PER_W-1:0] > PER_M1) ? PER_M1 : duty_q[PER_W-1:0];

    always_comb begin
        state_d = state_q;
        ph_d    = per_end ? '0 : ph_q + 1'b1;
        dly_d   = dly_q;
        hi_w_d  = hi_w_q;
        lo_w_d  = lo_w_q;
        unique case (state_q)
            TLP_ST_OFF: begin
                // a fresh start always begins from zero widths
                hi_w_d = '0;
                lo_w_d = '0;
                if (want_on) begin
                    state_d = TLP_ST_TONDLY;
                    dly_d   = ton_q;
                end
            end
            TLP_ST_TONDLY: begin
                if (!want_on)
                    state_d = TLP_ST_OFF;
                else if (per_end) begin
                    if (dly_q == 16'h0000) begin
                        state_d = TLP_ST_SS1;
                        dly_d   = 16'(TLP_STAGE1_PERIODS);
                    end else
                        dly_d = dly_q - 1'b1;
                end
            end
            TLP_ST_SS1, TLP_ST_SS2, TLP_ST_SS3, TLP_ST_RUN: begin
                if (!want_on) begin
                    state_d = TLP_ST_TOFDLY;
                    dly_d   = toff_q;
                end else if (per_end) begin
                    unique case (state_q)
                        TLP_ST_SS1: begin
                            if (hi_w_q < target) hi_w_d = hi_w_q + 1'b1;
                            dly_d = dly_q - 1'b1;
                            if (dly_q == 16'h0001) state_d = TLP_ST_SS2;
                        end
                        TLP_ST_SS2: begin
                            lo_w_d = lo_w_q + 1'b1;
                            if (hi_w_q < target) hi_w_d = hi_w_q + 1'b1;
                            if (hi_w_q + lo_w_q + 1'b1 >= PER_M1)
                                state_d = TLP_ST_SS3;
                        end
                        TLP_ST_SS3: begin
                            if (hi_w_q < target) hi_w_d = hi_w_q + 1'b1;
                            else state_d = TLP_ST_RUN;
                        end
                        default: ;
                    endcase
                end
            end
            TLP_ST_TOFDLY: begin
                // stays in the delay even if on is asked again
                if (per_end) begin
                    if (dly_q == 16'h0000) state_d = TLP_ST_OFF;
                    else dly_d = dly_q - 1'b1;
                end
            end
            default: state_d = TLP_ST_OFF;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q <= TLP_ST_OFF;
            ph_q    <= '0;
            dly_q   <= 16'h0000;
            hi_w_q  <= '0;
            lo_w_q  <= '0;
        end else begin
            state_q <= state_d;
            ph_q    <= ph_d;
            dly_q   <= dly_d;
            hi_w_q  <= hi_w_d;
            lo_w_q  <= lo_w_d;
        end
    end

    // level within a period: high first, then tri in SS1, tri then low at the end in SS2, low in SS3 and run
    always_comb begin
        lvl = TLP_LVL_TRI;
        unique case (state_q)
            TLP_ST_SS1:
                lvl = (ph_q < hi_w_q) ? TLP_LVL_HIGH : TLP_LVL_TRI;
            TLP_ST_SS2:
                if (ph_q < hi_w_q) lvl = TLP_LVL_HIGH;
                else if (ph_q > PER_M1 - lo_w_q) lvl = TLP_LVL_LOW;
            TLP_ST_SS3, TLP_ST_RUN:
                lvl = (ph_q < hi_w_q) ? TLP_LVL_HIGH : TLP_LVL_LOW;
            default: lvl = TLP_LVL_TRI;
        endcase
    end

    assign soft_start_done_out = (state_q == TLP_ST_RUN);

    tlp_tri_driver u_drv (
        .sys_clk_in         (sys_clk_in),
        .rst_b_in           (rst_b_in),
        .level_in           (lvl),
        .tri_lvl_25_in      (ctrl_q[TLP_CTRL_TRI25_BIT]),
        .pwm_hi_out         (pwm_hi_out),
        .pwm_lo_out         (pwm_lo_out),
        .pwm_tri_lvl_25_out (pwm_tri_lvl_25_out),
        .pwm_oe_b_out       (pwm_oe_b_out)
    );

endmodule : tlp_sequencer

// ---- tlp_sequencer_props.sv ----
// checker: port-level properties of the soft-start sequencer
`timescale 1ns/1ps
module tlp_sequencer_props
    import tlp_pkg::*;
#(
    parameter int PER_W  = 8,
    parameter int PERIOD = 100
) (
    // clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        rst_b_in,
    // register port
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [15:0] reg_rdata_out,
    // temperature and monitor
    input  wire logic [11:0] temp_sense_input_in,
    input  wire logic [11:0] temp_out,
    input  wire logic [7:0]  cm_range_mv_out,
    // phase pin
    input  wire logic        pwm_hi_out,
    input  wire logic        pwm_lo_out,
    input  wire logic        pwm_tri_lvl_25_out,
    input  wire logic        pwm_oe_b_out,
    input  wire logic        soft_start_done_out
);
    ////////////////////////////////////////
    logic       tri25_q, tri25_d;
    logic [7:0] cm_q, cm_d;
    logic       driven;

    function automatic logic [7:0] band(input logic [15:0] v);
        if (v <= TLP_RANGE_BRK1) return TLP_CM_24MV;
        if (v <= TLP_RANGE_BRK2) return TLP_CM_40MV;
        return TLP_CM_60MV;
    endfunction : band

    // clamping never moves a value across a band edge, so the raw write is enough
    always_comb begin
        tri25_d = tri25_q;
        cm_d    = cm_q;
        if (reg_wr_in && reg_addr_in == TLP_REG_CTRL) tri25_d = reg_wdata_in[TLP_CTRL_TRI25_BIT];
        if (reg_wr_in && reg_addr_in == TLP_REG_RSENSE) cm_d = band(reg_wdata_in);
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tri25_q <= TLP_CTRL_RST[TLP_CTRL_TRI25_BIT];
            cm_q    <= band(TLP_RSENSE_RST);
        end else begin
            tri25_q <= tri25_d;
            cm_q    <= cm_d;
        end
    end

    assign driven = pwm_hi_out | pwm_lo_out;

    ////////////////////////////////////////
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);

    sequence s_leave_drive;
        $past(driven) && !driven;
    endsequence
    sequence s_drive_then_release;
        !pwm_oe_b_out ##1 (pwm_oe_b_out || driven);
    endsequence

    a_never_both: assert property (!(pwm_hi_out && pwm_lo_out))
        else $error("high and low selected together");
    a_hiz_quiet: assert property (pwm_oe_b_out |-> !driven)
        else $error("level selected while pin released");
    a_entry_drive: assert property (s_leave_drive |-> s_drive_then_release)
        else $error("tri-state entry not driven for one cycle");
    a_entry_level: assert property (s_leave_drive |-> pwm_tri_lvl_25_out == tri25_q)
        else $error("tri-state entry level wrong");
    a_run_no_tri: assert property (soft_start_done_out |-> !pwm_oe_b_out)
        else $error("pin released in steady run");
    a_rsense_clamp: assert property ($past(reg_rd_in) && $past(reg_addr_in) == TLP_REG_RSENSE |->
        reg_rdata_out >= TLP_RSENSE_MIN && reg_rdata_out <= TLP_RSENSE_MAX) else $error("sense setting out of range");
    a_cm_follows: assert property ($past(cm_q) == cm_q && $past(cm_q, 2) == cm_q |-> cm_range_mv_out == cm_q)
        else $error("monitor range wrong");
    a_temp_diode: assert property ($past(rst_b_in) |-> temp_out == $past(temp_sense_input_in))
        else $error("temperature not from diode input");
    a_rdata_idle: assert property (!$past(reg_rd_in) || $past(reg_addr_in) > TLP_REG_STATUS |->
        reg_rdata_out == 16'h0000) else $error("read data not zero");
endmodule : tlp_sequencer_props

bind tlp_sequencer tlp_sequencer_props #(.PER_W(PER_W), .PERIOD(PERIOD)) i_props (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .temp_sense_input_in(temp_sense_input_in), .temp_out(temp_out), .cm_range_mv_out(cm_range_mv_out),
    .pwm_hi_out(pwm_hi_out), .pwm_lo_out(pwm_lo_out), .pwm_tri_lvl_25_out(pwm_tri_lvl_25_out),
    .pwm_oe_b_out(pwm_oe_b_out), .soft_start_done_out(soft_start_done_out)
);

// ---- tlp_stage_model.sv ----
// partner: behavioural power stage seen from the phase pin
`timescale 1ns/1ps
module tlp_stage_model
    import tlp_pkg::*;
(
    // clock and reset
    input  wire logic   sys_clk_in,
    input  wire logic   rst_b_in,
    // phase pin from the controller
    input  wire logic   pwm_hi_in,
    input  wire logic   pwm_lo_in,
    input  wire logic   pwm_oe_b_in,
    // telemetry and decoded level
    output logic [11:0] stage_temp_out,
    output tlp_level_e  level_out
);
    logic [11:0] tmp_q, tmp_d;

    // supply held valid from reset on, so every pulse is honoured
    // an open pin settles at the divider level: both switches off
    always_comb begin
        level_out = TLP_LVL_TRI;
        if (!pwm_oe_b_in && pwm_hi_in) level_out = TLP_LVL_HIGH;
        else if (!pwm_oe_b_in && pwm_lo_in) level_out = TLP_LVL_LOW;
    end

    // telemetry moves every cycle so a wrong source selection shows
    always_comb tmp_d = tmp_q + 12'h0a5;
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) tmp_q <= 12'h000;
        else tmp_q <= tmp_d;
    end
    assign stage_temp_out = tmp_q;
endmodule : tlp_stage_model

// ---- tlp_sequencer_tb.sv ----
// testbench: register port, start-up sequencing and pin behaviour
`timescale 1ns/1ps
module tlp_sequencer_tb
    import tlp_pkg::*;
;
    localparam int PER = 8;
    logic        sys_clk_in, rst_b_in, reg_wr_in, reg_rd_in, enable_pin_in, vin_ok_in;
    logic [3:0]  reg_addr_in;
    logic [15:0] reg_wdata_in, reg_rdata_out, w, e;
    logic [11:0] temp_sense_input_in = 12'h000;
    logic [11:0] stage_temp_output_in, temp_out, prev_ts;
    logic [7:0]  cm_range_mv_out;
    logic        pwm_hi_out, pwm_lo_out, pwm_tri_lvl_25_out, pwm_oe_b_out, soft_start_done_out;
    tlp_level_e  level;
    logic        polling = 1'b0, pend = 1'b0, poll_d = 1'b0, rst_d = 1'b0;
    logic [2:0]  last_st = 3'h0, mon_st = 3'h0;
    int          miscompares = 0, checks_done = 0, cycles = 0, age = 0;
    int          cyc [8] = '{default: 0};
    bit          seen [8][3] = '{default: '{default: 1'b0}};
    logic [15:0] exp_q [$];
    logic [2:0]  trans [$];
    logic [15:0] rs_w [6] = '{16'h0001, 16'hFFFF, 16'h0243, 16'h0244, 16'h0468, 16'h0469};
    logic [2:0]  exp_tr [8] = '{TLP_ST_TONDLY, TLP_ST_SS1, TLP_ST_SS2, TLP_ST_SS3, TLP_ST_RUN, TLP_ST_TOFDLY,
                                TLP_ST_OFF, TLP_ST_TONDLY};

    tlp_sequencer #(.PER_W(8), .PERIOD(PER)) i_dut (
        .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .enable_pin_in(enable_pin_in), .vin_ok_in(vin_ok_in), .temp_sense_input_in(temp_sense_input_in),
        .stage_temp_output_in(stage_temp_output_in), .temp_out(temp_out), .cm_range_mv_out(cm_range_mv_out),
        .pwm_hi_out(pwm_hi_out), .pwm_lo_out(pwm_lo_out), .pwm_tri_lvl_25_out(pwm_tri_lvl_25_out),
        .pwm_oe_b_out(pwm_oe_b_out), .soft_start_done_out(soft_start_done_out));

    tlp_stage_model i_stage (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .pwm_hi_in(pwm_hi_out),
        .pwm_lo_in(pwm_lo_out), .pwm_oe_b_in(pwm_oe_b_out), .stage_temp_out(stage_temp_output_in),
        .level_out(level));

    ////////////////////////////////////////
    initial begin
        sys_clk_in = 1'b0;
        forever #50 sys_clk_in = ~sys_clk_in;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask : check

    task automatic end_of_test;
        if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    // each access leaves one idle edge so no strobe is set and cleared in one step
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b0;
        @(posedge sys_clk_in);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [15:0] x);
        exp_q.push_back(x);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b0;
        @(posedge sys_clk_in);
    endtask : rd

    // back-to-back status reads until the state shows up
    task automatic poll_until(input logic [2:0] st, input int lim);
        int n;
        n = 0;
        reg_addr_in <= TLP_REG_STATUS;
        reg_rd_in   <= 1'b1;
        polling     <= 1'b1;
        while (last_st !== st && n < lim) begin
            @(posedge sys_clk_in);
            n++;
        end
        check(16'(last_st === st), 16'h0001);
        reg_rd_in <= 1'b0;
        polling   <= 1'b0;
        @(posedge sys_clk_in);
    endtask : poll_until

    ////////////////////////////////////////
    always @(posedge sys_clk_in) begin
        if (pend) check(reg_rdata_out, exp_q.pop_front());
        if (rst_d && rst_b_in) check(16'(temp_out), 16'(prev_ts));
        if (poll_d) begin
            if (reg_rdata_out[2:0] !== mon_st) begin
                mon_st = reg_rdata_out[2:0];
                trans.push_back(mon_st);
                age = 0;
            end
            cyc[mon_st]++;
            if (age >= 2) seen[mon_st][level] = 1'b1;
            age++;
        end
        last_st <= mon_st;
        pend    <= reg_rd_in && !polling;
        poll_d  <= polling;
        rst_d   <= rst_b_in;
        prev_ts = temp_sense_input_in;
        temp_sense_input_in <= 12'($urandom);
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            end_of_test();
        end
    end

    initial begin
        void'($urandom(32'h0927_493f));
        rst_b_in = 1'b0;
        reg_addr_in = 4'h0;
        reg_wdata_in = 16'h0000;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        enable_pin_in = 1'b0;
        vin_ok_in = 1'b0;
        repeat (16) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        @(posedge sys_clk_in);
        for (int a = 0; a < 8; a++) begin
            rd(4'(a), (a == 0) ? TLP_CTRL_RST : (a == 3) ? TLP_DUTY_RST : (a == 4) ? TLP_RSENSE_RST : 16'h0000);
        end
        rd(4'hF, 16'h0000);
        wr(TLP_REG_CTRL, 16'hFFEA);
        rd(TLP_REG_CTRL, 16'h000A);
        wr(TLP_REG_CTRL, 16'h0010);
        wr(TLP_REG_STATUS, 16'h1234);
        rd(TLP_REG_STATUS, 16'h0000);
        for (int i = 0; i < 10; i++) begin
            w = (i < 6) ? rs_w[i] : 16'(TLP_RSENSE_MIN + $urandom % (TLP_RSENSE_MAX - TLP_RSENSE_MIN + 1));
            e = (w < TLP_RSENSE_MIN) ? TLP_RSENSE_MIN : (w > TLP_RSENSE_MAX) ? TLP_RSENSE_MAX : w;
            wr(TLP_REG_RSENSE, w);
            rd(TLP_REG_RSENSE, e);
            check(16'(cm_range_mv_out), (e <= TLP_RANGE_BRK1) ? 16'h0018 : (e <= TLP_RANGE_BRK2) ? 16'h0028 : 16'h003C);
        end
        wr(TLP_REG_RSENSE, 16'h01F4);
        // command start gated by input voltage, with delays and 2.5 V entry level
        wr(TLP_REG_TON_DLY, 16'h0002);
        wr(TLP_REG_TOFF_DLY, 16'h0003);
        wr(TLP_REG_DUTY, 16'h0005);
        wr(TLP_REG_CTRL, 16'h000B);
        fork
            poll_until(TLP_ST_RUN, 3000);
            begin
                repeat (4) @(posedge sys_clk_in);
                vin_ok_in <= 1'b1;
            end
        join
        check(16'(soft_start_done_out), 16'h0001);
        check(16'(cyc[1] >= 2 * PER + 1 && cyc[1] <= 3 * PER), 16'h0001);
        check(16'(cyc[2]), 16'(TLP_STAGE1_PERIODS * PER));
        check(16'({seen[1][TLP_LVL_HIGH], seen[1][TLP_LVL_LOW]}), 16'h0000);
        check(16'({seen[2][TLP_LVL_HIGH], seen[2][TLP_LVL_LOW]}), 16'h0002);
        check(16'(seen[3][TLP_LVL_LOW]), 16'h0001);
        check(16'({seen[4][TLP_LVL_TRI], seen[5][TLP_LVL_TRI]}), 16'h0000);
        // early turn-on inside the off delay must wait for the full off state; 1.6 V entry
        wr(TLP_REG_CTRL, 16'h0002);
        poll_until(TLP_ST_TOFDLY, 40);
        wr(TLP_REG_CTRL, 16'h000B);
        poll_until(TLP_ST_TONDLY, 200);
        check(16'(trans.size()), 16'h0008);
        foreach (exp_tr[i]) check(16'(trans[i]), 16'(exp_tr[i]));
        // pin control alone, then loss of input voltage
        wr(TLP_REG_TON_DLY, 16'h0000);
        wr(TLP_REG_TOFF_DLY, 16'h0000);
        wr(TLP_REG_CTRL, 16'h0004);
        enable_pin_in <= 1'b1;
        poll_until(TLP_ST_SS1, 200);
        enable_pin_in <= 1'b0;
        poll_until(TLP_ST_OFF, 200);
        enable_pin_in <= 1'b1;
        poll_until(TLP_ST_SS1, 200);
        vin_ok_in <= 1'b0;
        poll_until(TLP_ST_OFF, 200);
        repeat (4) @(posedge sys_clk_in);
        check(16'({pwm_oe_b_out, pwm_hi_out, pwm_lo_out}), 16'h0004);
        end_of_test();
    end
endmodule : tlp_sequencer_tb
